// ===== design/rsp_pkg.sv
// package for the rf transceiver serial programming port
package rsp_pkg;
  localparam int RSP_WORD_BITS = 18;
  localparam int RSP_DATA_BITS = 14;
  localparam int RSP_ADDR_BITS = 4;
  localparam int RSP_CNT_W = 5;
  // serial clock half period in system clock cycles
  localparam int RSP_HALF_DIV = 8;
  localparam int RSP_DIV_W = 8;
  // select setup and hold around the clock, in half periods
  localparam int RSP_GAP_HALVES = 1;
  localparam logic [RSP_CNT_W-1:0] RSP_LAST_BIT = 5'h11;

  typedef enum logic [1:0] {
    RSP_IDLE,
    RSP_LEAD,
    RSP_SHIFT,
    RSP_TRAIL
  } rsp_state_type;

  typedef struct packed {
    logic [RSP_DATA_BITS-1:0] data;
    logic [RSP_ADDR_BITS-1:0] addr;
  } rsp_word_type;

  typedef struct packed {
    logic serial_clock;
    logic select_n;
    logic serial_data;
  } rsp_pins_type;
endpackage : rsp_pkg

// ===== design/rsp_serial_port.sv
// serial programming port master that loads rf transceiver registers
// Function
// - one burst is exactly 18 bits with select held low throughout
// - data field first, four address bits shifted out last
// - data changes on falling clock edges, stable at rising edges
// - word shifted most significant bit first
// - bursts accepted in any mode, no mode gating
module rsp_serial_port
  import rsp_pkg::*;
#(
  parameter int HALF_DIV = RSP_HALF_DIV
)(
  input wire logic i_mclk, // system clock 125 MHz
  input wire logic i_reset_n, // async reset, active low
  input wire logic i_req_valid, // request to send a word
  input wire rsp_pkg::rsp_word_type i_req_word, // data and address
  output logic o_req_ready, // port idle, request taken
  output logic o_busy, // burst in progress
  output rsp_pkg::rsp_pins_type o_pins // serial pins to transceiver
);
  import rsp_pkg::*;

  typedef struct packed {
    rsp_state_type state;
    logic [RSP_DIV_W-1:0] div;
    logic [RSP_CNT_W-1:0] bit_idx;
    logic [RSP_WORD_BITS-1:0] shreg;
    rsp_pins_type pins;
  } rsp_regs_type;

  rsp_regs_type st_r;
  rsp_regs_type st_nxt;
  logic tick;

  assign tick = (st_r.div == RSP_DIV_W'(HALF_DIV - 1));
  assign o_req_ready = (st_r.state == RSP_IDLE);
  assign o_busy = (st_r.state != RSP_IDLE);
  assign o_pins = st_r.pins;

  always_comb
  begin
    st_nxt = st_r;
    // divider held at zero when idle, so every half period is full
    if (st_r.state == RSP_IDLE || tick)
      st_nxt.div = '0;
    else
      st_nxt.div = st_r.div + RSP_DIV_W'(1);
    unique case (st_r.state)
      RSP_IDLE:
      begin
        st_nxt.pins.serial_clock = 1'b0;
        st_nxt.pins.select_n = 1'b1;
        if (i_req_valid)
        begin
          st_nxt.shreg = {i_req_word.data, i_req_word.addr};
          st_nxt.bit_idx = '0;
          st_nxt.state = RSP_LEAD;
          st_nxt.pins.select_n = 1'b0;
          st_nxt.pins.serial_data = i_req_word.data[RSP_DATA_BITS-1];
        end
      end
      RSP_LEAD:
        if (tick)
        begin
          st_nxt.state = RSP_SHIFT;
          st_nxt.pins.serial_clock = 1'b1;
        end
      RSP_SHIFT:
        if (tick)
        begin
          if (st_r.pins.serial_clock)
          begin
            st_nxt.pins.serial_clock = 1'b0;
            if (st_r.bit_idx == RSP_LAST_BIT)
              st_nxt.state = RSP_TRAIL;
            else
            begin
              st_nxt.shreg = {st_r.shreg[RSP_WORD_BITS-2:0], 1'b0};
              st_nxt.pins.serial_data = st_r.shreg[RSP_WORD_BITS-2];
              st_nxt.bit_idx = st_r.bit_idx + RSP_CNT_W'(1);
            end
          end
          else
            st_nxt.pins.serial_clock = 1'b1;
        end
      RSP_TRAIL:
        if (tick)
        begin
          st_nxt.pins.select_n = 1'b1;
          st_nxt.pins.serial_data = 1'b0;
          st_nxt.state = RSP_IDLE;
        end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st_r.state <= RSP_IDLE;
      st_r.div <= '0;
      st_r.bit_idx <= '0;
      st_r.shreg <= '0;
      // select high, clock low from reset
      st_r.pins.serial_clock <= 1'b0;
      st_r.pins.select_n <= 1'b1;
      st_r.pins.serial_data <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  // rising clock count inside one burst, for checks only
  logic [RSP_CNT_W:0] rise_cnt;
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      rise_cnt <= '0;
    else if (st_r.pins.select_n)
      rise_cnt <= '0;
    else if (st_nxt.pins.serial_clock && !st_r.pins.serial_clock)
      rise_cnt <= rise_cnt + (RSP_CNT_W+1)'(1);
  end

  // word as taken, so the bit checks need not trust the shifter
  logic [RSP_WORD_BITS-1:0] chk_word;
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      chk_word <= '0;
    else if (o_req_ready && i_req_valid)
      chk_word <= i_req_word;
  end

  // cycles the clock pin has stood at its present level, saturating
  logic [RSP_DIV_W-1:0] hold_cnt;
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      hold_cnt <= '0;
    else if (st_nxt.pins.serial_clock != st_r.pins.serial_clock)
      hold_cnt <= RSP_DIV_W'(1);
    else if (hold_cnt != '1)
      hold_cnt <= hold_cnt + RSP_DIV_W'(1);
  end

  AST_BURST_18: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    $rose(o_pins.select_n) |->
      rise_cnt == (RSP_CNT_W+1)'(RSP_WORD_BITS))
    else $error("burst did not carry 18 clocks");

  AST_IDLE_PINS: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    o_pins.select_n |->
      !o_pins.serial_clock)
    else $error("clock high while select high");

  AST_DATA_STABLE: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    o_pins.serial_clock |->
      $stable(o_pins.serial_data))
    else $error("data changed while clock high");

  AST_MSB_FIRST: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    (o_req_ready && i_req_valid) |=>
      o_pins.serial_data == $past(i_req_word.data[RSP_DATA_BITS-1]))
    else $error("first bit is not the msb");

  AST_BURST_ENDS: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    (o_req_ready && i_req_valid) |=>
      ##[1:1000] o_pins.select_n)
    else $error("burst did not end");

  AST_SEL_LOW: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    $rose(o_pins.serial_clock) |->
      !o_pins.select_n)
    else $error("clock edge outside select frame");

  AST_BIT_ORDER: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    $rose(o_pins.serial_clock) |->
      o_pins.serial_data == chk_word[RSP_WORD_BITS - int'(rise_cnt)])
    else $error("bit at rising clock is out of order");

  AST_ADDR_LAST: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    $rose(o_pins.select_n) |->
      $past(o_pins.serial_data) == chk_word[0])
    else $error("last bit is not the address lsb");

  AST_CLK_HALF: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    $fell(o_pins.serial_clock) |->
      $past(hold_cnt) == RSP_DIV_W'(HALF_DIV))
    else $error("clock high time is not one half period");

  AST_SEL_TAKEN: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    $fell(o_pins.select_n) |->
      $past(o_req_ready) && $past(i_req_valid))
    else $error("select fell without a taken request");

  AST_IDLE_DATA: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    o_pins.select_n |->
      !o_pins.serial_data)
    else $error("data high while select high");

  AST_READY_IDLE: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    o_req_ready |->
      o_pins.select_n && !o_pins.serial_clock)
    else $error("ready while pins not idle");
endmodule : rsp_serial_port

// ===== dv/rsp_xcvr_model.sv
// behavioural transceiver on the far side of the serial port
module rsp_xcvr_model
  import rsp_pkg::*;
(
  input wire rsp_pkg::rsp_pins_type i_pins, // serial pins
  output logic [RSP_WORD_BITS-1:0] o_word, // last loaded word
  output logic [7:0] o_bits, // bits in last burst
  output logic [7:0] o_loads // load count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [RSP_WORD_BITS-1:0] shift_r;
  // one driver per counter: burst length is a difference of totals
  logic [7:0] rises_r = 8'h00;
  logic [7:0] start_r = 8'h00;
  logic [7:0] loads_r = 8'h00;
  assign o_loads = loads_r;
  always @(posedge i_pins.serial_clock)
    if (!i_pins.select_n)
    begin
      shift_r <= {shift_r[RSP_WORD_BITS-2:0], i_pins.serial_data};
      rises_r <= rises_r + 8'h01;
    end
  always @(negedge i_pins.select_n)
    start_r <= rises_r;
  // load on select rise, any clock level
  always @(posedge i_pins.select_n)
  begin
    o_word <= shift_r;
    o_bits <= rises_r - start_r;
    loads_r <= loads_r + 8'h01;
  end
endmodule : rsp_xcvr_model

// ===== dv/rf_transceiver_serial_program_port_test.sv
// self-checking bench for the serial programming port
module rf_transceiver_serial_program_port_test
  import rsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_req_valid = 1'b0;
  rsp_word_type i_req_word = 18'h00000;
  logic o_req_ready, o_busy;
  rsp_pins_type o_pins;
  logic [17:0] m_word;
  logic [7:0] m_bits;
  logic [7:0] m_loads;
  int errors = 0, samples_checked = 0, cycles = 0, stray = 0;
  // default divider gives the nearest serial clock to 125 ns
  rsp_serial_port #(.HALF_DIV(RSP_HALF_DIV)) DUT (.i_mclk(i_mclk),
    .i_reset_n(i_reset_n), .i_req_valid(i_req_valid),
    .i_req_word(i_req_word), .o_req_ready(o_req_ready),
    .o_busy(o_busy), .o_pins(o_pins));
  rsp_xcvr_model model (.i_pins(o_pins), .o_word(m_word),
    .o_bits(m_bits), .o_loads(m_loads));
  initial
  begin
    forever #4 i_mclk = ~i_mclk;
  end
  always @(posedge o_pins.serial_clock)
    if (o_pins.select_n !== 1'b0)
      stray++;
  always @(posedge i_mclk)
  begin
    cycles++;
    // about twenty bursts of some 300 cycles, with slack
    if (cycles == 15000)
    begin
      errors++;
      summarize();
    end
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // stall keeps a second word offered while busy; it must be refused
  task automatic send(rsp_word_type w, logic stall);
    logic [7:0] n;
    int k;
    int exp_k;
    n = m_loads;
    // lead gap, 35 half periods of clocking, trail gap
    exp_k = (2 * RSP_GAP_HALVES + 2 * RSP_WORD_BITS - 1) * RSP_HALF_DIV;
    @(negedge i_mclk);
    i_req_valid = 1'b1;
    i_req_word = w;
    @(negedge i_mclk);
    check("busy", o_busy, 1'h1);
    i_req_word = ~w;
    i_req_valid = stall;
    for (k = 0; k < 400 && o_req_ready !== 1'b1; k++)
      @(negedge i_mclk);
    i_req_valid = 1'b0;
    check("ready", o_req_ready, 1'h1);
    check("cycles", k, exp_k);
    check("word", m_word, w);
    check("bits", m_bits, 8'h12);
    check("addr", m_word[3:0], w.addr);
    check("loads", m_loads, n + 8'h01);
    check("idle", {o_pins.select_n, o_pins.serial_clock}, 2'h2);
  endtask : send
  task automatic test_addresses();
    for (int a = 0; a < 16; a++)
      send({14'h2d5a ^ {a[3:0], 10'h000}, a[3:0]}, 1'b0);
    $display("test_addresses done");
  endtask : test_addresses
  task automatic test_refuse();
    send(18'h3ffff, 1'b1);
    send(18'h00000, 1'b1);
    $display("test_refuse done");
  endtask : test_refuse
  // reset in mid-burst must drop the pins to idle at once
  task automatic test_reset();
    @(negedge i_mclk);
    i_req_valid = 1'b1;
    i_req_word = 18'h2a5c3;
    @(negedge i_mclk);
    i_req_valid = 1'b0;
    repeat (100) @(negedge i_mclk);
    check("mid busy", o_busy, 1'h1);
    i_reset_n = 1'b0;
    repeat (2) @(negedge i_mclk);
    check("reset pins", o_pins, 3'h2);
    check("reset ready", o_req_ready, 1'h1);
    i_reset_n = 1'b1;
    send(18'h1c3a7, 1'b0);
    $display("test_reset done");
  endtask : test_reset
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (8) @(negedge i_mclk);
    i_reset_n = 1'b1;
    test_addresses();
    test_refuse();
    test_reset();
    check("stray", stray, 32'h0);
    summarize();
  end
endmodule : rf_transceiver_serial_program_port_test
